/* include/psmc_defs.svh */
`ifndef PSMC_DEFS_SVH
`define PSMC_DEFS_SVH

// system clock source select codes
`define PSMC_SRC_PRIMARY 2'h0
`define PSMC_SRC_FAST_RC 2'h1
`define PSMC_SRC_SECONDARY 2'h2
`define PSMC_SRC_LOW_POWER_RC 2'h3
// widths
`define PSMC_DIV_W 3
`define PSMC_POST_W 3
`define PSMC_PERIPH_N 8
`define PSMC_WDT_W 16
// reset values
`define PSMC_SRC_RESET 2'h1
`define PSMC_DIV_RESET 3'h0
`define PSMC_POST_RESET 3'h0

`endif

/* include/psmc_pkg.sv */
package psmc_pkg;
  // power state of the controller
  typedef enum logic [2:0] {
    PSMC_RUN = 3'h1,
    PSMC_IDLE = 3'h2,
    PSMC_SLEEP = 3'h4
  } psmc_state_t;

  // software configuration, written as one bundle
  typedef struct packed {
    logic [1:0] src_sel;
    logic post_en;
    logic [2:0] post_ratio;
    logic pb_scale_en;
    logic [2:0] pb_ratio;
    logic sleep_sel;
    logic [7:0] idle_stop;
    logic [7:0] own_clock;
  } psmc_cfg_t;

  // gate enables presented to the clock tree
  typedef struct packed {
    logic cpu_clk_en;
    logic sys_src_run;
    logic pb_tick;
    logic [7:0] periph_clk_en;
  } psmc_gate_t;
endpackage

/* rtl/psmc_ratio_div.sv */
`timescale 1ns/1ps
`include "psmc_defs.svh"

// divides by 2**ratio, emitting a one-cycle tick; ratio 0 ticks every cycle
module psmc_ratio_div (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic [`PSMC_DIV_W-1:0] ratio,
  output logic tick
);
  logic [7:0] count;
  logic [7:0] limit;

  always_comb begin
    limit = 8'h00;
    limit[ratio] = 1'b1;
  end

  // count stops while the source is halted, so no tick leaks out in sleep
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      count <= 8'h00;
    end else if (!run) begin
      count <= count;
    end else if (count >= limit - 8'h01) begin
      count <= 8'h00;
    end else begin
      count <= count + 8'h01;
    end
  end

  assign tick = run && (count >= limit - 8'h01);
endmodule // psmc_ratio_div

/* rtl/psmc_power_ctrl.sv */
`timescale 1ns/1ps
`include "psmc_defs.svh"

// Notes on behaviour
// [RQ1] modes change only on software request
// [RQ2] cpu runs from software-selected oscillator
// [RQ3] peripheral bus clock is divided system clock
// [RQ4] idle and sleep stop cpu clock
// [RQ5] idle keeps selected clock source running
// [RQ6] idle keeps peripherals clocked unless disabled
// [RQ7] sleep halts cpu, source, system peripherals
// [RQ8] sleep spares peripherals with own clocks
// [RQ9] sleep entry leaves watchdog counter untouched
// [RQ10] halt request picks idle or sleep
module psmc_power_ctrl (
  input wire logic mclk,
  input wire logic rst_n,
  input wire psmc_pkg::psmc_cfg_t cfg,
  input wire logic halt_req,
  input wire logic wake_event,
  input wire logic [`PSMC_PERIPH_N-1:0] periph_en,
  input wire logic watchdog_en,
  input wire logic watchdog_clear,
  output psmc_pkg::psmc_gate_t gate,
  output logic [1:0] fast_rc_osc_en_sel,
  output logic [`PSMC_POST_W-1:0] post_ratio,
  output logic post_en,
  output logic in_idle,
  output logic in_sleep,
  output logic [`PSMC_WDT_W-1:0] watchdog_counter,
  output logic watchdog_timeout
);
  psmc_pkg::psmc_state_t state;
  psmc_pkg::psmc_state_t next_state;
  logic src_run;
  logic pb_tick_raw;
  logic [`PSMC_DIV_W-1:0] pb_ratio_eff;
  logic cpu_clk_en_q;
  logic sys_src_run_q;
  logic pb_tick_q;
  logic [`PSMC_PERIPH_N-1:0] periph_clk_en_q;

  // one process per flop group, then packed onto the output bundle so no
  // struct member is written from two processes
  assign gate = {cpu_clk_en_q, sys_src_run_q, pb_tick_q, periph_clk_en_q};

  // state moves only on the cpu halt request or a wake event
  always_comb begin
    next_state = state;
    case (state)
      psmc_pkg::PSMC_RUN: begin
        if (halt_req) begin // RQ1
          next_state = cfg.sleep_sel ? psmc_pkg::PSMC_SLEEP : psmc_pkg::PSMC_IDLE; // RQ10
        end
      end
      psmc_pkg::PSMC_IDLE,
      psmc_pkg::PSMC_SLEEP: begin
        if (wake_event) begin
          next_state = psmc_pkg::PSMC_RUN; // RQ10
        end
      end
      default: next_state = psmc_pkg::PSMC_RUN;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state <= psmc_pkg::PSMC_RUN;
    end else begin
      state <= next_state;
    end
  end

  // the source keeps running in run and idle; only sleep shuts it down
  assign src_run = (next_state != psmc_pkg::PSMC_SLEEP); // RQ5 RQ7

  // scaling off means the bus runs at the full system rate
  assign pb_ratio_eff = cfg.pb_scale_en ? cfg.pb_ratio : `PSMC_DIV_RESET;

  psmc_ratio_div u_pb_div (
    .mclk(mclk),
    .rst_n(rst_n),
    .run(src_run),
    .ratio(pb_ratio_eff),
    .tick(pb_tick_raw)
  );

  // gate enables, registered so every output comes from a flip-flop
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cpu_clk_en_q <= 1'b1;
      sys_src_run_q <= 1'b1;
      pb_tick_q <= 1'b0;
    end else begin
      cpu_clk_en_q <= (next_state == psmc_pkg::PSMC_RUN); // RQ4
      sys_src_run_q <= src_run; // RQ5 RQ7
      pb_tick_q <= pb_tick_raw; // RQ3
    end
  end

  // per-peripheral clock enables
  genvar i;
  generate
    for (i = 0; i < `PSMC_PERIPH_N; i++) begin : g_periph
      always_ff @(posedge mclk) begin
        if (!rst_n) begin
          periph_clk_en_q[i] <= 1'b0;
        end else if (cfg.own_clock[i]) begin
          periph_clk_en_q[i] <= periph_en[i]; // RQ8
        end else begin
          case (next_state)
            psmc_pkg::PSMC_IDLE: periph_clk_en_q[i] <= periph_en[i] && !cfg.idle_stop[i]; // RQ6
            psmc_pkg::PSMC_SLEEP: periph_clk_en_q[i] <= 1'b0; // RQ7
            default: periph_clk_en_q[i] <= periph_en[i];
          endcase
        end
      end
    end
  endgenerate

  // oscillator select held across modes; a glitch-free mux downstream switches it
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      fast_rc_osc_en_sel <= `PSMC_SRC_RESET;
      post_ratio <= `PSMC_POST_RESET;
      post_en <= 1'b0;
    end else begin
      fast_rc_osc_en_sel <= cfg.src_sel; // RQ2
      post_ratio <= cfg.post_ratio; // RQ2
      post_en <= cfg.post_en && (cfg.src_sel == `PSMC_SRC_FAST_RC); // RQ2
    end
  end

  // mode status flags
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      in_idle <= 1'b0;
      in_sleep <= 1'b0;
    end else begin
      in_idle <= (next_state == psmc_pkg::PSMC_IDLE);
      in_sleep <= (next_state == psmc_pkg::PSMC_SLEEP);
    end
  end

  // watchdog runs on its own clock domain in silicon, modelled as a tick
  // here; sleep entry deliberately does not clear it
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      watchdog_counter <= '0;
      watchdog_timeout <= 1'b0;
    end else if (!watchdog_en || watchdog_clear) begin
      watchdog_counter <= '0; // software clear or watchdog disable only, never mode entry RQ9
      watchdog_timeout <= 1'b0;
    end else begin
      watchdog_counter <= watchdog_counter + 1'b1; // RQ9
      watchdog_timeout <= (watchdog_counter == {`PSMC_WDT_W{1'b1}});
    end
  end
endmodule // psmc_power_ctrl

/* verification/psmc_chk.sv */
`timescale 1ns/1ps
module psmc_chk (
  input wire logic mclk,
  input wire logic rst_n,
  input wire psmc_pkg::psmc_cfg_t cfg,
  input wire logic halt_req,
  input wire logic wake_event,
  input wire logic [7:0] periph_en,
  input wire psmc_pkg::psmc_gate_t gate,
  input wire logic in_idle,
  input wire logic in_sleep
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // go marks a halt taken while running
  wire run = !in_idle && !in_sleep;
  wire go = run && halt_req;
  property p_sl; go && cfg.sleep_sel |=> in_sleep && !gate.sys_src_run; endproperty
  a_sl: assert property (p_sl) else $error("sleep");
  property p_id; go && !cfg.sleep_sel |=> in_idle && !gate.cpu_clk_en && gate.sys_src_run; endproperty
  a_id: assert property (p_id) else $error("idle");
  property p_rn; run && !halt_req |=> run; endproperty
  a_rn: assert property (p_rn) else $error("run");
  property p_hd; !run && !wake_event |=> $stable({in_idle, in_sleep}); endproperty
  a_hd: assert property (p_hd) else $error("hold");
  property p_wk; !run && wake_event |=> run && gate.cpu_clk_en; endproperty
  a_wk: assert property (p_wk) else $error("wake");
  property p_pi; in_idle && !wake_event && !cfg.own_clock |=>
    gate.periph_clk_en == $past(periph_en & ~cfg.idle_stop); endproperty
  a_pi: assert property (p_pi) else $error("idle gates");
  property p_ps; in_sleep && !wake_event |=>
    gate.periph_clk_en == $past(periph_en & cfg.own_clock); endproperty
  a_ps: assert property (p_ps) else $error("sleep gates");
  property p_pb; in_sleep && $past(in_sleep) |-> !gate.pb_tick; endproperty
  a_pb: assert property (p_pb) else $error("bus tick");
  // main scenarios
  cover property (go);
  cover property (in_sleep);
  cover property (!run && wake_event);
endmodule // psmc_chk
bind psmc_power_ctrl psmc_chk u_chk (.*);

/* verification/power_saving_mode_control_tb.sv */
`timescale 1ns/1ps
module power_saving_mode_control_tb;
  logic mclk = 0, rst_n = 0, halt_req = 0, wake_event = 0, watchdog_en = 1;
  logic watchdog_clear = 0, post_en, in_idle, in_sleep, watchdog_timeout;
  logic [7:0] periph_en = 8'hFF;
  logic [15:0] watchdog_counter, w0;
  logic [1:0] fast_rc_osc_en_sel;
  logic [2:0] post_ratio;
  psmc_pkg::psmc_cfg_t cfg = '0;
  psmc_pkg::psmc_gate_t gate;
  int num_errors = 0, total_checks = 0, cyc = 0;
  // source, flags, gates in one word so one compare covers a whole state
  wire [14:0] st = {fast_rc_osc_en_sel, post_en, in_idle, in_sleep, gate.cpu_clk_en,
    gate.sys_src_run, gate.periph_clk_en};
  psmc_power_ctrl dut (.*);
  task chk(input logic [31:0] s, e);
    total_checks++;
    if (s !== e) begin
      num_errors++;
      $display("[FAIL] %0t %0h %0h", $time, s, e);
    end
  endtask
  task conclude;
    $display("errors %0d checks %0d", num_errors, total_checks);
    if (num_errors == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // clock, and a cycle ceiling so a hang still reports
  initial forever #2.5 mclk = ~mclk;
  always @(posedge mclk) if (++cyc == 3000) begin
    num_errors++;
    conclude;
  end
  // h=1 halts in mode s, h=0 wakes; driven off the sampling edge
  task req(input logic h, s);
    @(negedge mclk);
    cfg.sleep_sel = s;
    halt_req = h;
    wake_event = !h;
    @(negedge mclk);
    halt_req = 0;
    wake_event = 0;
  endtask
  task t_idle;
    cfg.src_sel = 2'h3;
    cfg.post_en = 1;
    cfg.idle_stop = 8'h0E;
    periph_en = 8'h3C;
    req(1, 0);
    chk(st, 15'h6930);
    req(0, 0);
    chk(st[11:8], 4'h3);
  endtask
  task t_sleep;
    cfg.src_sel = 2'h1;
    cfg.own_clock = 8'h81;
    periph_en = 8'hFF;
    w0 = watchdog_counter;
    req(1, 1);
    chk(st, 15'h3481);
    chk(watchdog_counter > w0, 1'h1);
    req(1, 0);
    chk(st, 15'h3481);
    req(0, 1);
    chk(st[11:8], 4'h3);
  endtask
  // bus scaling by four, tick stops in sleep, postscaler ratio, watchdog clear
  task t_pb;
    int n;
    n = 0;
    @(negedge mclk);
    cfg.pb_scale_en = 1;
    cfg.pb_ratio = 3'h2;
    cfg.post_ratio = 3'h5;
    repeat (8) @(negedge mclk);
    chk(post_ratio, 3'h5);
    repeat (16) begin
      @(negedge mclk);
      n += gate.pb_tick;
    end
    chk(n, 4);
    req(1, 1);
    n = 0;
    repeat (8) begin
      @(negedge mclk);
      n += gate.pb_tick;
    end
    chk(n, 0);
    req(0, 1);
    watchdog_clear = 1;
    @(negedge mclk);
    chk(watchdog_counter, 16'h0000);
    chk(watchdog_timeout, 1'h0);
    watchdog_clear = 0;
  endtask
  initial begin
    repeat (16) @(negedge mclk);
    rst_n = 1;
    t_idle;
    t_sleep;
    t_pb;
    conclude;
  end
endmodule // power_saving_mode_control_tb
